// [pkg/cmpc_pkg.sv]
// Package with register map, field positions and reset values for the comparator control block.
package cmpc_pkg;
  localparam int            CMPC_NUM            = 2;
  localparam logic [7:0]    CMPC_ADDR_CTRL0_C1  = 8'h00;
  localparam logic [7:0]    CMPC_ADDR_CTRL1_C1  = 8'h04;
  localparam logic [7:0]    CMPC_ADDR_CTRL0_C2  = 8'h08;
  localparam logic [7:0]    CMPC_ADDR_CTRL1_C2  = 8'h0c;
  localparam logic [7:0]    CMPC_ADDR_MIRROR    = 8'h10;
  localparam logic [7:0]    CMPC_ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0]    CMPC_ADDR_IRQ_CLR   = 8'h18;
  localparam logic [7:0]    CMPC_ADDR_IRQ_EN    = 8'h1c;
  localparam int            CMPC_B_ENABLE       = 7;
  localparam int            CMPC_B_RESULT       = 6;
  localparam int            CMPC_B_INVERT       = 4;
  localparam int            CMPC_B_SPEED        = 2;
  localparam int            CMPC_B_HYST         = 1;
  localparam int            CMPC_B_SYNC         = 0;
  localparam int            CMPC_B_RISE_EN      = 7;
  localparam int            CMPC_B_FALL_EN      = 6;
  localparam logic [7:0]    CMPC_CTRL0_WMASK    = 8'h97;
  localparam logic [7:0]    CMPC_CTRL0_RESET    = 8'h04;
  localparam logic [7:0]    CMPC_CTRL1_RESET    = 8'h00;
  localparam logic [2:0]    CMPC_POS_PIN0       = 3'h0;
  localparam logic [2:0]    CMPC_POS_DAC        = 3'h5;
  localparam logic [2:0]    CMPC_POS_FVR        = 3'h6;
  localparam logic [2:0]    CMPC_POS_GND        = 3'h7;
  localparam logic [2:0]    CMPC_NEG_FVR        = 3'h6;
  localparam logic [2:0]    CMPC_NEG_GND        = 3'h7;
  localparam logic [1:0]    CMPC_RESP_OKAY      = 2'h0;
  localparam logic [1:0]    CMPC_RESP_SLVERR    = 2'h2;
endpackage

// [verilog/cmpc_top.sv]
// Control and status registers for two analog comparators, reached over AXI4-Lite.
// Contract
// R1: Control 0 bit 7 enables the comparator; clear disables it.
// R2: Control 0 bit 6 reads the polarity-handled result; writes ignored.
// R3: Polarity bit 4 set inverts the reported result.
// R4: Speed bit 2 resets to 1; software must not write 0.
// R5: Bit 1 drives hysteresis enable to the analog core.
// R6: Sync bit 0 set updates forwarded result on timer clock falling edge.
// R7: Rising-edge enable lets a 0-to-1 result transition set the flag.
// R8: Falling-edge enable lets a 1-to-0 result transition set the flag.
// R9: Positive select codes pick pin 0, DAC, reference, ground or nothing.
// R10: Negative select codes 000-011 pick pins 0-3, 110 reference, 111 ground.
// R11: Negative select codes 100 and 101 leave the input unconnected.
// R12: Mirror register bit 1 copies comparator 2, bit 0 comparator 1.
// R13: Unimplemented bits read zero and ignore writes.
// R14: Everything resets to 0 except the speed bit, which resets to 1.
// R15: Flag cleared only by software; an edge during clear keeps it set.
// R16: Toggling polarity or enable while disabled can still raise an edge.
// R17: Raw result is registered each clock before edge detection and reads.
// R18: Two comparators, own control registers and flags, one shared mirror.
`timescale 1ns/1ps
module cmpc_top
  import cmpc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [CMPC_NUM-1:0]  raw_compare,
  input  wire logic                 timer_clk_src,
  output logic [CMPC_NUM-1:0]       comparator_enable,
  output logic [CMPC_NUM-1:0]       speed_power_select,
  output logic [CMPC_NUM-1:0]       hysteresis_enable,
  output logic [3*CMPC_NUM-1:0]     pos_input_select,
  output logic [3*CMPC_NUM-1:0]     neg_input_select,
  output logic [4*CMPC_NUM-1:0]     pos_input_node_sel,
  output logic [6*CMPC_NUM-1:0]     neg_input_node_sel,
  output logic [CMPC_NUM-1:0]       gate_result,
  output logic [CMPC_NUM-1:0]       edge_event_flag,
  output logic                      irq
);

  logic [7:0]          ctrl0_ff [CMPC_NUM];
  logic [7:0]          ctrl1_ff [CMPC_NUM];
  logic [CMPC_NUM-1:0] raw_meta_ff;
  logic [CMPC_NUM-1:0] raw_sync_ff;
  logic [CMPC_NUM-1:0] compare_result;
  logic [CMPC_NUM-1:0] result_prev_ff;
  logic [CMPC_NUM-1:0] flag_ff;
  logic [CMPC_NUM-1:0] irq_en_ff;
  logic [CMPC_NUM-1:0] gate_ff;
  logic [CMPC_NUM-1:0] event_set;
  logic [CMPC_NUM-1:0] clr_hit;
  logic                tclk_meta_ff;
  logic                tclk_sync_ff;
  logic                tclk_prev_ff;
  logic                tclk_fall;
  logic                aw_held_ff;
  logic                w_held_ff;
  logic [7:0]          awaddr_ff;
  logic [31:0]         wdata_ff;
  logic [3:0]          wstrb_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                rvalid_ff;
  logic [31:0]         rdata_ff;
  logic [1:0]          rresp_ff;
  logic                wr_go;
  logic                wr_hit;
  logic                wr_lane0;
  logic [7:0]          wr_byte;
  logic [31:0]         nxt_rdata;
  logic                nxt_rhit;
  logic [CMPC_NUM-1:0] wr_ctrl0_sel;
  logic [CMPC_NUM-1:0] wr_ctrl1_sel;
  logic                wr_clr_sel;
  logic                wr_en_sel;

  // Write channel: address and data are captured independently, then committed together.
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign wr_go         = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_lane0      = wstrb_ff[0];
  assign wr_byte       = wdata_ff[7:0];

  // Writes to the read-only mirror and status words are accepted and have no effect.
  always_comb begin
    wr_hit       = 1'b1;
    wr_ctrl0_sel = '0;
    wr_ctrl1_sel = '0;
    wr_clr_sel   = 1'b0;
    wr_en_sel    = 1'b0;
    case (awaddr_ff & 8'hfc)
      CMPC_ADDR_CTRL0_C1: begin
        wr_ctrl0_sel[0] = 1'b1;
      end
      CMPC_ADDR_CTRL1_C1: begin
        wr_ctrl1_sel[0] = 1'b1;
      end
      CMPC_ADDR_CTRL0_C2: begin
        wr_ctrl0_sel[1] = 1'b1;
      end
      CMPC_ADDR_CTRL1_C2: begin
        wr_ctrl1_sel[1] = 1'b1;
      end
      CMPC_ADDR_IRQ_CLR: begin
        wr_clr_sel = 1'b1;
      end
      CMPC_ADDR_IRQ_EN: begin
        wr_en_sel = 1'b1;
      end
      CMPC_ADDR_MIRROR, CMPC_ADDR_IRQ_STAT: begin
        wr_hit = 1'b1; // R13
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= CMPC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? CMPC_RESP_OKAY : CMPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Timer clock source is asynchronous; its falling edge is found after two flip-flops.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tclk_meta_ff <= 1'b0;
      tclk_sync_ff <= 1'b0;
      tclk_prev_ff <= 1'b0;
    end else begin
      tclk_meta_ff <= timer_clk_src;
      tclk_sync_ff <= tclk_meta_ff;
      tclk_prev_ff <= tclk_sync_ff;
    end
  end

  assign tclk_fall = tclk_prev_ff && !tclk_sync_ff;

  // Both comparator results pass two flip-flops, which also latches them once per clock.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      raw_meta_ff <= '0;
      raw_sync_ff <= '0;
    end else begin
      raw_meta_ff <= raw_compare;
      raw_sync_ff <= raw_meta_ff; // R17
    end
  end

  // The enable word gates only the interrupt; flags still set while it is clear.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_en_ff <= '0;
    end else if (wr_go && wr_lane0 && wr_en_sel) begin
      irq_en_ff <= wr_byte[CMPC_NUM-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CMPC_NUM; gi++) begin : g_cmp
      logic [3:0] nxt_pos_sel;
      logic [5:0] nxt_neg_sel;
      logic [3:0] pos_sel_ff;
      logic [5:0] neg_sel_ff;

      // The result bit and unimplemented bits are masked off, so writes to them are dropped.
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          ctrl0_ff[gi] <= CMPC_CTRL0_RESET; // R14 R4
        end else if (wr_go && wr_lane0 && wr_ctrl0_sel[gi]) begin
          ctrl0_ff[gi] <= wr_byte & CMPC_CTRL0_WMASK; // R2 R13
        end
      end

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          ctrl1_ff[gi] <= CMPC_CTRL1_RESET; // R14
        end else if (wr_go && wr_lane0 && wr_ctrl1_sel[gi]) begin
          ctrl1_ff[gi] <= wr_byte;
        end
      end

      // A disabled comparator reads as low before polarity, so toggling enable or polarity moves the result.
      assign compare_result[gi] = (raw_sync_ff[gi] & ctrl0_ff[gi][CMPC_B_ENABLE])
                                ^ ctrl0_ff[gi][CMPC_B_INVERT]; // R3 R16 R1

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          result_prev_ff[gi] <= 1'b0;
        end else begin
          result_prev_ff[gi] <= compare_result[gi];
        end
      end

      // Edges are taken from the registered result, so each transition counts once.
      assign event_set[gi] = (compare_result[gi] && !result_prev_ff[gi] && ctrl1_ff[gi][CMPC_B_RISE_EN])  // R7
                           || (!compare_result[gi] && result_prev_ff[gi] && ctrl1_ff[gi][CMPC_B_FALL_EN]); // R8
      assign clr_hit[gi]   = wr_go && wr_lane0 && wr_clr_sel && wr_byte[gi];

      // Set wins over a clearing write in the same cycle, so a racing edge is never lost.
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          flag_ff[gi] <= 1'b0;
        end else if (event_set[gi]) begin
          flag_ff[gi] <= 1'b1; // R15
        end else if (clr_hit[gi]) begin
          flag_ff[gi] <= 1'b0; // R15
        end
      end

      // With sync set the forwarded result only moves on a timer clock falling edge.
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          gate_ff[gi] <= 1'b0;
        end else if (!ctrl0_ff[gi][CMPC_B_SYNC] || tclk_fall) begin
          gate_ff[gi] <= compare_result[gi]; // R6
        end
      end

      assign comparator_enable[gi]  = ctrl0_ff[gi][CMPC_B_ENABLE]; // R1
      assign speed_power_select[gi] = ctrl0_ff[gi][CMPC_B_SPEED]; // R4
      assign hysteresis_enable[gi]  = ctrl0_ff[gi][CMPC_B_HYST]; // R5
      assign pos_input_select[3*gi +: 3] = ctrl1_ff[gi][5:3];
      assign neg_input_select[3*gi +: 3] = ctrl1_ff[gi][2:0];

      // Node selects are registered so the analog switches never see decode glitches.
      // Positive bits are {ground, reference, DAC, pin 0}; a disabled comparator selects nothing.
      always_comb begin
        nxt_pos_sel = 4'h0;
        case (ctrl1_ff[gi][5:3])
          CMPC_POS_PIN0: nxt_pos_sel = 4'h1; // R9
          CMPC_POS_DAC:  nxt_pos_sel = 4'h2; // R9
          CMPC_POS_FVR:  nxt_pos_sel = 4'h4; // R9
          CMPC_POS_GND:  nxt_pos_sel = 4'h8; // R9
          default:       nxt_pos_sel = 4'h0; // R9
        endcase
        if (!ctrl0_ff[gi][CMPC_B_ENABLE]) begin
          nxt_pos_sel = 4'h0; // R1
        end
      end

      // Negative bits are {ground, reference, pin 3, pin 2, pin 1, pin 0}; codes 100 and 101 select nothing.
      always_comb begin
        nxt_neg_sel = 6'h00;
        case (ctrl1_ff[gi][2:0])
          3'h0, 3'h1, 3'h2, 3'h3: nxt_neg_sel = 6'(6'h01 << ctrl1_ff[gi][1:0]); // R10
          CMPC_NEG_FVR:           nxt_neg_sel = 6'h10; // R10
          CMPC_NEG_GND:           nxt_neg_sel = 6'h20; // R10
          default:                nxt_neg_sel = 6'h00; // R11
        endcase
        if (!ctrl0_ff[gi][CMPC_B_ENABLE]) begin
          nxt_neg_sel = 6'h00; // R1
        end
      end

      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          pos_sel_ff <= 4'h0;
          neg_sel_ff <= 6'h00;
        end else begin
          pos_sel_ff <= nxt_pos_sel;
          neg_sel_ff <= nxt_neg_sel;
        end
      end

      assign pos_input_node_sel[4*gi +: 4] = pos_sel_ff;
      assign neg_input_node_sel[6*gi +: 6] = neg_sel_ff;
    end
  endgenerate

  assign gate_result     = gate_ff;
  assign edge_event_flag = flag_ff;
  // The interrupt is a level, high while any enabled flag is set.
  assign irq             = |(flag_ff & irq_en_ff);

  // Read channel: one read at a time, answered the cycle after the address is taken.
  assign s_axi_arready = !rvalid_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rhit  = 1'b1;
    case (s_axi_araddr & 8'hfc)
      CMPC_ADDR_CTRL0_C1: nxt_rdata[7:0] = ctrl0_ff[0] | {1'b0, compare_result[0], 6'h00}; // R2
      CMPC_ADDR_CTRL1_C1: nxt_rdata[7:0] = ctrl1_ff[0];
      CMPC_ADDR_CTRL0_C2: nxt_rdata[7:0] = ctrl0_ff[1] | {1'b0, compare_result[1], 6'h00}; // R18
      CMPC_ADDR_CTRL1_C2: nxt_rdata[7:0] = ctrl1_ff[1];
      CMPC_ADDR_MIRROR:   nxt_rdata[7:0] = {6'h00, compare_result[1], compare_result[0]}; // R12 R13
      CMPC_ADDR_IRQ_STAT: nxt_rdata[7:0] = {6'h00, flag_ff};
      CMPC_ADDR_IRQ_CLR:  nxt_rdata[7:0] = 8'h00;
      CMPC_ADDR_IRQ_EN:   nxt_rdata[7:0] = {6'h00, irq_en_ff};
      default: begin
        nxt_rhit = 1'b0;
      end
    endcase
  end

  // Read data is captured at the address handshake and held until rready.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= CMPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rhit ? CMPC_RESP_OKAY : CMPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule

// [verification/cmpc_analog_model.sv]
// Behavioural model of the analog comparator core and the timer clock source.
`timescale 1ns/1ps
module cmpc_analog_model (
  input wire logic       core_clk,
  input wire logic [1:0] pos_above,
  input wire logic [1:0] comparator_enable,
  input wire logic       slow,
  output logic [1:0]     raw_compare,
  output logic           timer_clk_src
);
  logic [1:0] dly_ff [4] = '{default: 2'h0};
  logic [2:0] div_ff = 3'h0;
  // A disabled core draws no power and its output rests low; slow mode adds response time.
  always @(posedge core_clk) begin
    dly_ff[0] <= pos_above & comparator_enable;
    for (int i = 1; i < 4; i++) begin
      dly_ff[i] <= dly_ff[i - 1];
    end
  end
  always @(posedge core_clk) begin
    div_ff <= div_ff + 3'h1;
  end
  assign raw_compare = slow ? dly_ff[3] : dly_ff[0];
  assign timer_clk_src = div_ff[2];
endmodule

// [verification/cmpc_top_chk.sv]
// Assertion checker for the comparator control block ports.
`timescale 1ns/1ps
module cmpc_top_chk (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [1:0]  comparator_enable,
  input wire logic [1:0]  speed_power_select,
  input wire logic [5:0]  pos_input_select,
  input wire logic [5:0]  neg_input_select,
  input wire logic [7:0]  pos_input_node_sel,
  input wire logic [11:0] neg_input_node_sel,
  input wire logic [1:0]  edge_event_flag,
  input wire logic        irq
);
  import cmpc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped early");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_rst_val; $rose(reset_n) |-> speed_power_select == 2'h3 && comparator_enable == 2'h0 && !irq; endproperty
  a_rst_val: assert property (p_rst_val) else $error("wrong value after reset");
  property p_flag_clr; $fell(edge_event_flag[0]) || $fell(edge_event_flag[1]) |-> $rose(s_axi_bvalid); endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag cleared without a write");
  property p_off; (!comparator_enable[0]) [*2] |-> pos_input_node_sel[3:0] == 4'h0 && neg_input_node_sel[5:0] == 6'h0; endproperty
  a_off: assert property (p_off) else $error("inputs selected while disabled");
  property p_pos_gnd; (comparator_enable[0] && pos_input_select[2:0] == CMPC_POS_GND) [*2] |-> pos_input_node_sel[3:0] == 4'h8; endproperty
  a_pos_gnd: assert property (p_pos_gnd) else $error("positive ground not selected");
  property p_neg_open; (comparator_enable[0] && neg_input_select[2:1] == 2'h2) [*2] |-> neg_input_node_sel[5:0] == 6'h0; endproperty
  a_neg_open: assert property (p_neg_open) else $error("negative input not left open");
endmodule
bind cmpc_top cmpc_top_chk cmpc_top_chk_inst (.core_clk(core_clk), .reset_n(reset_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .comparator_enable(comparator_enable),
  .speed_power_select(speed_power_select), .pos_input_select(pos_input_select),
  .neg_input_select(neg_input_select), .pos_input_node_sel(pos_input_node_sel),
  .neg_input_node_sel(neg_input_node_sel), .edge_event_flag(edge_event_flag), .irq(irq));

// [verification/test_cmpc_top.sv]
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
module test_cmpc_top;
  import cmpc_pkg::*;
  logic        core_clk = 1'b0, reset_n = 1'b0, slow = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pos_input_node_sel;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, timer_clk_src;
  logic [1:0]  pos_above = 2'h0, s_axi_bresp, s_axi_rresp, raw_compare, comparator_enable;
  logic [1:0]  speed_power_select, hysteresis_enable, gate_result, edge_event_flag;
  logic [5:0]  pos_input_select, neg_input_select;
  logic [11:0] neg_input_node_sel;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          n;
  cmpc_top cmpc_top_inst (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .raw_compare(raw_compare),
    .timer_clk_src(timer_clk_src), .comparator_enable(comparator_enable),
    .speed_power_select(speed_power_select), .hysteresis_enable(hysteresis_enable),
    .pos_input_select(pos_input_select), .neg_input_select(neg_input_select),
    .pos_input_node_sel(pos_input_node_sel), .neg_input_node_sel(neg_input_node_sel),
    .gate_result(gate_result), .edge_event_flag(edge_event_flag), .irq(irq));
  cmpc_analog_model cmpc_analog_model_inst (.core_clk(core_clk), .pos_above(pos_above),
    .comparator_enable(comparator_enable), .slow(slow), .raw_compare(raw_compare),
    .timer_clk_src(timer_clk_src));
  task automatic stop_test();
    $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // One register access; wr selects a write, otherwise d is the expected read data.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic        ta, tw, tr;
    logic [1:0]  rsp;
    logic [31:0] got;
    int          i;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (i = 0; i < 50; i++) begin
      @(negedge core_clk);
      ta = wr ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      tr = wr ? s_axi_bvalid : s_axi_rvalid;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      got = s_axi_rdata;
      @(posedge core_clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) break;
    end
    if (i == 50) begin
      error_cnt++;
      stop_test();
    end
    chk(32'(rsp), 32'(r));
    if (!wr) chk(got, {24'h0, d});
  endtask
  task automatic lvl(input logic [1:0] a, input logic [1:0] f, input logic q);
    pos_above <= a;
    tick(12);
    chk(32'(edge_event_flag), 32'(f));
    chk(32'(irq), 32'(q));
  endtask
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    tick(12);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) acc(1'b0, 8'(i * 4), (i < 4 && i % 2 == 0) ? 8'h04 : 8'h00, CMPC_RESP_OKAY);
    chk(32'(speed_power_select), 32'h3);
    acc(1'b0, 8'h20, 8'h00, CMPC_RESP_SLVERR);
    acc(1'b1, 8'h20, 8'h00, CMPC_RESP_SLVERR);
    acc(1'b1, CMPC_ADDR_CTRL0_C1, 8'hff, CMPC_RESP_OKAY);
    tick(12);
    acc(1'b0, CMPC_ADDR_CTRL0_C1, 8'hd7, CMPC_RESP_OKAY);
    chk(32'(hysteresis_enable), 32'h1);
    acc(1'b0, CMPC_ADDR_MIRROR, 8'h01, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_CTRL0_C1, 8'hec, CMPC_RESP_OKAY);
    acc(1'b0, CMPC_ADDR_CTRL0_C1, 8'h84, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_CTRL0_C2, 8'h84, CMPC_RESP_OKAY);
    pos_above <= 2'h2;
    tick(12);
    acc(1'b0, CMPC_ADDR_CTRL0_C2, 8'hc4, CMPC_RESP_OKAY);
    acc(1'b0, CMPC_ADDR_MIRROR, 8'h02, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_CTRL1_C1, 8'h80, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_IRQ_EN, 8'h03, CMPC_RESP_OKAY);
    lvl(2'h3, 2'h1, 1'b1);
    acc(1'b0, CMPC_ADDR_IRQ_STAT, 8'h01, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_IRQ_CLR, 8'h01, CMPC_RESP_OKAY);
    lvl(2'h2, 2'h0, 1'b0);
    acc(1'b1, CMPC_ADDR_CTRL1_C1, 8'h40, CMPC_RESP_OKAY);
    lvl(2'h3, 2'h0, 1'b0);
    lvl(2'h2, 2'h1, 1'b1);
    acc(1'b1, CMPC_ADDR_IRQ_EN, 8'h02, CMPC_RESP_OKAY);
    lvl(2'h2, 2'h1, 1'b0);
    acc(1'b1, CMPC_ADDR_IRQ_CLR, 8'h01, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_CTRL0_C1, 8'h04, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_CTRL1_C1, 8'h80, CMPC_RESP_OKAY);
    acc(1'b1, CMPC_ADDR_CTRL0_C1, 8'h14, CMPC_RESP_OKAY);
    lvl(2'h2, 2'h1, 1'b0);
    acc(1'b1, CMPC_ADDR_CTRL0_C1, 8'h84, CMPC_RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, CMPC_ADDR_CTRL1_C1, {2'h0, 3'(c), 3'(c)}, CMPC_RESP_OKAY);
      tick(2);
      chk(32'(pos_input_node_sel[3:0]), c == 0 ? 32'h1 : c > 4 ? 32'h1 << (c - 4) : 32'h0);
      chk(32'(neg_input_node_sel[5:0]), c < 4 ? 32'h1 << c : c > 5 ? 32'h1 << (c - 2) : 32'h0);
      chk(32'({pos_input_select[2:0], neg_input_select[2:0]}), 32'(c * 9));
    end
    acc(1'b1, CMPC_ADDR_CTRL0_C2, 8'h85, CMPC_RESP_OKAY);
    slow <= 1'b1;
    tick(12);
    chk(32'(gate_result[1]), 32'h1);
    chk(32'(comparator_enable), 32'h3);
    chk(32'({pos_input_node_sel[7:4], neg_input_node_sel[11:6]}), 32'h41);
    pos_above <= 2'h0;
    for (n = 0; n < 40 && gate_result[1] !== 1'b0; n++) @(negedge core_clk);
    chk(32'(n < 40), 32'h1);
    chk(32'(timer_clk_src), 32'h0);
    stop_test();
  end
endmodule
